// file: hw/mpt_defines.svh
// Purpose: Constants for the MAC port timing configuration register bank
// Assumes: 32-bit AHB-Lite data bus, one aligned word per register
// Notes:   Writable masks clear reserved bits on every write
// Behaviour
// - General config bit 0 enables port mirroring; resets to zero.
// - Receive FIFO threshold is three bits: bits 6-5 here, top bit elsewhere.
// - Receive defaults recovered mode; threshold two-to-one saves 8/40/400 ns.
// - Transmit FIFO threshold is three bits: bits 4-3 here, top bit elsewhere.
// - Transmit clock bit zero means shifted, one means aligned with data.
// - Receive clock bit zero drives shifted clock, one drives aligned clock.
// - Bypass bit one routes data around the asynchronous FIFO.
// - Bypass delay bit one delays receive clock at 10/100 speeds.
// - Low-latency bit one selects reduced-latency 10/100 datapath.
`ifndef MPT_DEFINES_SVH
`define MPT_DEFINES_SVH

// =====================================================================
// Register indices and byte addresses
`define MPT_IDX_GEN_CFG        7'h31
`define MPT_IDX_PORT_CTRL      7'h32
`define MPT_IDX_PORT_CTRL2     7'h33
`define MPT_ADDR_GEN_CFG       32'h0000_00c4
`define MPT_ADDR_PORT_CTRL     32'h0000_00c8
`define MPT_ADDR_PORT_CTRL2    32'h0000_00cc

// =====================================================================
// Field positions
`define MPT_GEN_MIRROR_BIT     0
`define MPT_CTL_SPARE_BIT      7
`define MPT_CTL_RX_THR_HI      6
`define MPT_CTL_RX_THR_LO      5
`define MPT_CTL_TX_THR_HI      4
`define MPT_CTL_TX_THR_LO      3
`define MPT_CTL_TX_ERR_BIT     2
`define MPT_CTL_TX_CLK_BIT     1
`define MPT_CTL_RX_CLK_BIT     0
`define MPT_CT2_BYPASS_BIT     4
`define MPT_CT2_BYP_DLY_BIT    3
`define MPT_CT2_LOW_LAT_BIT    2
`define MPT_CT2_RX_THR_MSB     1
`define MPT_CT2_TX_THR_MSB     0

// =====================================================================
// Reset values and writable masks
`define MPT_RST_GEN_CFG        16'h0000
`define MPT_RST_PORT_CTRL      16'h00d0
`define MPT_RST_PORT_CTRL2     16'h0000
`define MPT_MASK_GEN_CFG       16'h0001
`define MPT_MASK_PORT_CTRL     16'h00ff
`define MPT_MASK_PORT_CTRL2    16'h001f

// =====================================================================
// Latency saved by receive threshold one instead of two
`define MPT_SAVE_1G_NS         10'd8
`define MPT_SAVE_100M_NS       10'd40
`define MPT_SAVE_10M_NS        10'd400
`define MPT_THR_SHORT          3'h1

`endif

// file: hw/mpt_pkg.sv
// Purpose: Types for the MAC port timing configuration register bank
// Assumes: Constants come from mpt_defines.svh
// Notes:   Config outputs travel as one packed struct
package mpt_pkg;

  typedef enum logic [1:0] {
    MPT_SPEED_10M,
    MPT_SPEED_100M,
    MPT_SPEED_1G,
    MPT_SPEED_RSVD
  } mpt_speed_t;

  typedef struct packed {
    logic       port_mirror_enable;
    logic [2:0] rx_sync_fifo_threshold;
    logic [2:0] tx_sync_fifo_threshold;
    logic       tx_error_suppress_enable;
    logic       tx_clock_aligned;
    logic       rx_clock_aligned;
    logic       async_fifo_bypass_enable;
    logic       bypass_rx_clock_delay_enable;
    logic       low_latency_enable;
  } mpt_cfg_t;

  typedef struct packed {
    logic       rx_clock_delay_active;
    logic       low_latency_active;
    logic       rx_short_threshold;
    logic [9:0] rx_latency_saved_ns;
  } mpt_path_t;

endpackage

// file: hw/mpt_regs.sv
// Purpose: MAC port timing configuration registers behind an AHB-Lite slave
// Assumes: Single-word transfers only; zero wait states; always OKAY
// Notes:   Three 16-bit registers in the low half of each word
`timescale 1ns/1ns
`default_nettype none
`include "mpt_defines.svh"

module mpt_regs (
  input  wire logic               core_clk_i,
  input  wire logic               sys_rst_i,
  input  wire logic               hsel_i,
  input  wire logic [31:0]        haddr_i,
  input  wire logic [1:0]         htrans_i,
  input  wire logic               hwrite_i,
  input  wire logic [2:0]         hsize_i,
  input  wire logic [31:0]        hwdata_i,
  input  wire logic               hready_i,
  output logic      [31:0]        hrdata_o,
  output logic                    hreadyout_o,
  output logic                    hresp_o,
  input  wire logic               rx_recovered_mode_i,
  input  wire mpt_pkg::mpt_speed_t link_speed_i,
  output mpt_pkg::mpt_cfg_t       cfg_o,
  output mpt_pkg::mpt_path_t      path_o
);
  import mpt_pkg::*;

  logic [15:0] gen_cfg_q;
  logic [15:0] port_ctrl_q;
  logic [15:0] port_ctrl2_q;
  logic        wr_pend_q;
  logic [31:0] wr_addr_q;
  logic [31:0] hrdata_q;
  logic        addr_phase;
  logic [15:0] rd_val;
  logic [15:0] wdat;
  logic        fast_speed;
  logic [9:0]  save_ns;

  // ===================================================================
  // Bus slave
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign hrdata_o    = hrdata_q;
  assign addr_phase  = hsel_i & hready_i & htrans_i[1];
  assign wdat        = hwdata_i[15:0];

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 32'h0000_0000;
    end
    else if (hready_i)
    begin
      wr_pend_q <= addr_phase & hwrite_i;
      wr_addr_q <= haddr_i;
    end
  end

  // Unmapped addresses and reserved bits read zero
  always_comb
  begin
    case (haddr_i)
      `MPT_ADDR_GEN_CFG:    rd_val = gen_cfg_q & `MPT_MASK_GEN_CFG;
      `MPT_ADDR_PORT_CTRL:  rd_val = port_ctrl_q & `MPT_MASK_PORT_CTRL;
      `MPT_ADDR_PORT_CTRL2: rd_val = port_ctrl2_q & `MPT_MASK_PORT_CTRL2;
      default:              rd_val = 16'h0000;
    endcase
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      hrdata_q <= 32'h0000_0000;
    else if (addr_phase & ~hwrite_i)
      hrdata_q <= {16'h0000, rd_val};
  end

  // ===================================================================
  // Registers
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      gen_cfg_q <= `MPT_RST_GEN_CFG;
    else if (wr_pend_q && wr_addr_q == `MPT_ADDR_GEN_CFG)
      gen_cfg_q <= wdat & `MPT_MASK_GEN_CFG;
  end

  // Bit 7 is plain storage; software is expected to keep it set
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      port_ctrl_q <= `MPT_RST_PORT_CTRL;
    else if (wr_pend_q && wr_addr_q == `MPT_ADDR_PORT_CTRL)
      port_ctrl_q <= wdat & `MPT_MASK_PORT_CTRL;
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      port_ctrl2_q <= `MPT_RST_PORT_CTRL2;
    else if (wr_pend_q && wr_addr_q == `MPT_ADDR_PORT_CTRL2)
      port_ctrl2_q <= wdat & `MPT_MASK_PORT_CTRL2;
  end

  // ===================================================================
  // Configuration outputs
  always_comb
  begin
    cfg_o.port_mirror_enable = gen_cfg_q[`MPT_GEN_MIRROR_BIT];
    cfg_o.rx_sync_fifo_threshold = {port_ctrl2_q[`MPT_CT2_RX_THR_MSB],
      port_ctrl_q[`MPT_CTL_RX_THR_HI:`MPT_CTL_RX_THR_LO]};
    cfg_o.tx_sync_fifo_threshold = {port_ctrl2_q[`MPT_CT2_TX_THR_MSB],
      port_ctrl_q[`MPT_CTL_TX_THR_HI:`MPT_CTL_TX_THR_LO]};
    cfg_o.tx_error_suppress_enable = port_ctrl_q[`MPT_CTL_TX_ERR_BIT];
    cfg_o.tx_clock_aligned = port_ctrl_q[`MPT_CTL_TX_CLK_BIT];
    cfg_o.rx_clock_aligned = port_ctrl_q[`MPT_CTL_RX_CLK_BIT];
    cfg_o.async_fifo_bypass_enable = port_ctrl2_q[`MPT_CT2_BYPASS_BIT];
    cfg_o.bypass_rx_clock_delay_enable = port_ctrl2_q[`MPT_CT2_BYP_DLY_BIT];
    cfg_o.low_latency_enable = port_ctrl2_q[`MPT_CT2_LOW_LAT_BIT];
  end

  // ===================================================================
  // Speed-qualified datapath selects
  assign fast_speed = (link_speed_i == MPT_SPEED_10M) | (link_speed_i == MPT_SPEED_100M);

  always_comb
  begin
    case (link_speed_i)
      MPT_SPEED_1G:   save_ns = `MPT_SAVE_1G_NS;
      MPT_SPEED_100M: save_ns = `MPT_SAVE_100M_NS;
      MPT_SPEED_10M:  save_ns = `MPT_SAVE_10M_NS;
      default:        save_ns = 10'h000;
    endcase
  end

  always_comb
  begin
    path_o.rx_clock_delay_active = port_ctrl2_q[`MPT_CT2_BYP_DLY_BIT] & fast_speed;
    path_o.low_latency_active = port_ctrl2_q[`MPT_CT2_LOW_LAT_BIT] & fast_speed;
    path_o.rx_short_threshold = rx_recovered_mode_i
      & (cfg_o.rx_sync_fifo_threshold == `MPT_THR_SHORT);
    path_o.rx_latency_saved_ns = path_o.rx_short_threshold ? save_ns : 10'h000;
  end

endmodule
`default_nettype wire

// file: bench/mpt_regs_assertions.sv
// Purpose: Port assertions for the config register bank
// Assumes: Bound to mpt_regs from the bench top
// Notes:   One clock domain, reset disables all
`timescale 1ns/1ns
`default_nettype none
`include "mpt_defines.svh"
module mpt_regs_assertions (
  input wire logic                core_clk_i,
  input wire logic                sys_rst_i,
  input wire logic                hsel_i,
  input wire logic                hwrite_i,
  input wire logic                rx_recovered_mode_i,
  input wire logic [1:0]          htrans_i,
  input wire logic [31:0]         haddr_i,
  input wire logic [31:0]         hwdata_i,
  input wire mpt_pkg::mpt_speed_t link_speed_i,
  input wire mpt_pkg::mpt_cfg_t   cfg_o,
  input wire mpt_pkg::mpt_path_t  path_o
);
  import mpt_pkg::*;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  // ==========================================================
  // Register updates
  cfg_cause_a:
    assert property (!$stable(cfg_o) |-> $past(hsel_i && htrans_i[1] && hwrite_i, 2))
    else $error("config changed without a write");
  mirror_wr_a:
    assert property ((hsel_i && htrans_i[1] && hwrite_i && haddr_i == `MPT_ADDR_GEN_CFG) ##1 1'b1
      |=> cfg_o.port_mirror_enable == $past(hwdata_i[0])) else $error("mirror bit wrong");
  ctrl_wr_a:
    assert property ((hsel_i && htrans_i[1] && hwrite_i && haddr_i == `MPT_ADDR_PORT_CTRL)
      ##1 1'b1 |=> {cfg_o.rx_sync_fifo_threshold[1:0], cfg_o.tx_sync_fifo_threshold[1:0],
      cfg_o.tx_clock_aligned, cfg_o.rx_clock_aligned} == {$past(hwdata_i[6:3]),
      $past(hwdata_i[1:0])}) else $error("control fields wrong");
  // ==========================================================
  // Speed qualified outputs
  rx_dly_a:
    assert property (path_o.rx_clock_delay_active == (cfg_o.bypass_rx_clock_delay_enable
      && link_speed_i < MPT_SPEED_1G)) else $error("clock delay wrong");
  low_lat_a:
    assert property (path_o.low_latency_active == (cfg_o.low_latency_enable
      && link_speed_i < MPT_SPEED_1G)) else $error("low latency wrong");
  short_thr_a:
    assert property (path_o.rx_short_threshold == (rx_recovered_mode_i
      && cfg_o.rx_sync_fifo_threshold == 3'h1)) else $error("short threshold wrong");
  save_fast_a:
    assert property (path_o.rx_short_threshold && link_speed_i == MPT_SPEED_1G
      |-> path_o.rx_latency_saved_ns == 10'h008) else $error("gigabit saving wrong");
  save_mid_a:
    assert property (path_o.rx_short_threshold && link_speed_i == MPT_SPEED_100M
      |-> path_o.rx_latency_saved_ns == 10'h028) else $error("100M saving wrong");
  save_slow_a:
    assert property (path_o.rx_short_threshold && link_speed_i == MPT_SPEED_10M
      |-> path_o.rx_latency_saved_ns == 10'h190) else $error("10M saving wrong");
endmodule
`default_nettype wire

// file: bench/mpt_mac_model.sv
// Purpose: Far-side MAC model giving speed and receive clock mode
// Assumes: Levels change only between frames
// Notes:   Requests appear one edge later
`timescale 1ns/1ns
`default_nettype none
module mpt_mac_model (
  input  wire logic          core_clk_i,
  input  wire logic [1:0]    speed_req_i,
  input  wire logic          recovered_req_i,
  output mpt_pkg::mpt_speed_t link_speed_o,
  output logic               rx_recovered_mode_o
);
  import mpt_pkg::*;
  always_ff @(posedge core_clk_i)
  begin
    link_speed_o <= mpt_speed_t'(speed_req_i);
    rx_recovered_mode_o <= recovered_req_i;
  end
endmodule
`default_nettype wire

// file: bench/mpt_regs_tb.sv
// Purpose: Self-checking bench for the config register bank
// Assumes: Zero-wait slave; master idles between transfers
// Notes:   Control bit 7 is always written as one
`timescale 1ns/1ns
`default_nettype none
`include "mpt_defines.svh"
module mpt_regs_tb;
  import mpt_pkg::*;
  logic        clk = 0, rst = 1, sel = 0, wr = 0, rdy, rsp, rec = 1, lrec;
  logic [1:0]  tr = 0, spd = 2'h2;
  logic [31:0] ad = 0, wd = 0, rd, rv;
  logic [9:0]  sav [4] = '{10'h190, 10'h028, 10'h008, 10'h000};
  mpt_speed_t  lspd;
  mpt_cfg_t    cfg;
  mpt_path_t   path;
  int          fail_count = 0, checked = 0;
  mpt_mac_model mac_u (.core_clk_i(clk), .speed_req_i(spd), .recovered_req_i(rec),
    .link_speed_o(lspd), .rx_recovered_mode_o(lrec));
  mpt_regs dut_u (.core_clk_i(clk), .sys_rst_i(rst), .hsel_i(sel), .haddr_i(ad),
    .htrans_i(tr), .hwrite_i(wr), .hsize_i(3'h2), .hwdata_i(wd), .hready_i(rdy),
    .hrdata_o(rd), .hreadyout_o(rdy), .hresp_o(rsp), .rx_recovered_mode_i(lrec),
    .link_speed_i(lspd), .cfg_o(cfg), .path_o(path));
  initial forever #2 clk = ~clk;
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e || rsp !== 1'b0)
    begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    sel <= 1;
    tr <= 2'h2;
    wr <= w;
    ad <= a;
    do @(posedge clk); while (rdy !== 1'b1);
    sel <= 0;
    tr <= 2'h0;
    wd <= d;
    do @(posedge clk); while (rdy !== 1'b1);
    rv = rd;
  endtask
  task automatic rchk(input string n, input logic [31:0] a, input logic [31:0] e);
    xfer(0, a, 32'h0000_0000);
    cmp(n, e, rv);
  endtask
  task automatic t_reset();
    rchk("gen", `MPT_ADDR_GEN_CFG, 32'h0000_0000);
    rchk("ctrl", `MPT_ADDR_PORT_CTRL, 32'h0000_00d0);
    rchk("ctrl2", `MPT_ADDR_PORT_CTRL2, 32'h0000_0000);
    cmp("thr", 32'h0000_0012, 32'({cfg.rx_sync_fifo_threshold, cfg.tx_sync_fifo_threshold}));
    $display("reset test done");
  endtask
  task automatic t_fields();
    xfer(1, `MPT_ADDR_GEN_CFG, 32'hffff_ffff);
    rchk("gen", `MPT_ADDR_GEN_CFG, 32'h0000_0001);
    xfer(1, `MPT_ADDR_PORT_CTRL, 32'hffff_ffff);
    rchk("ctrl", `MPT_ADDR_PORT_CTRL, 32'h0000_00ff);
    xfer(1, `MPT_ADDR_PORT_CTRL2, 32'hffff_ffff);
    rchk("ctrl2", `MPT_ADDR_PORT_CTRL2, 32'h0000_001f);
    xfer(1, 32'h0000_00d0, 32'hffff_ffff);
    rchk("unmapped", 32'h0000_00d0, 32'h0000_0000);
    cmp("cfg", 32'h0000_1fff, 32'(cfg));
    $display("field test done");
  endtask
  task automatic t_path();
    xfer(1, `MPT_ADDR_PORT_CTRL, 32'h0000_00a0);
    xfer(1, `MPT_ADDR_PORT_CTRL2, 32'h0000_000c);
    for (int s = 0; s < 4; s++)
    begin
      spd <= 2'(s);
      repeat (2) @(posedge clk);
      cmp("path", 32'({1'(s < 2), 1'(s < 2), 1'b1, sav[s]}), 32'(path));
    end
    rec <= 0;
    spd <= 2'h0;
    repeat (2) @(posedge clk);
    cmp("no short", 32'h0000_1800, 32'(path));
    xfer(1, `MPT_ADDR_PORT_CTRL2, 32'h0000_0000);
    rchk("ctrl2", `MPT_ADDR_PORT_CTRL2, 32'h0000_0000);
    cmp("cleared", 32'h0000_0000, 32'({cfg.async_fifo_bypass_enable, path}));
    $display("path test done");
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    t_reset();
    t_fields();
    t_path();
    end_sim();
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    fail_count++;
    end_sim();
  end
endmodule
bind mpt_regs mpt_regs_assertions chk_u (.core_clk_i, .sys_rst_i, .hsel_i, .hwrite_i,
  .rx_recovered_mode_i, .htrans_i, .haddr_i, .hwdata_i, .link_speed_i, .cfg_o, .path_o);
`default_nettype wire
